/* hw/ppc_pkg.sv */
// Purpose: Constants and types of the proximity offset calibration controller
// Assumes: Byte registers reached through the serial register port
// Notes:   Shared by the controller, its checker and the bench; addresses, reset values, field positions and sizes live here
package ppc_pkg;
    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS = 8'h9b;
    localparam logic [7:0] ADDR_ISCFG  = 8'hab;
    localparam logic [7:0] ADDR_PCCFG  = 8'hae;
    localparam logic [7:0] ADDR_OFFMAG = 8'hc0;
    localparam logic [7:0] ADDR_OFFSGN = 8'hc1;
    localparam logic [7:0] ADDR_CALCTL = 8'hd7;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ISCFG  = 8'h01;
    localparam logic [7:0] RST_PCCFG  = 8'h3f;
    localparam logic [7:0] RST_OFFMAG = 8'h00;
    localparam logic [7:0] RST_OFFSGN = 8'h00;
    localparam logic [7:0] RST_CALCTL = 8'h00;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_RDCLR   = 7;
    localparam int BIT_SAI     = 4;
    localparam int BIT_PCOFF   = 6;
    localparam int BIT_SIGN    = 0;
    localparam int BIT_CAL_AVERAGING_ON  = 7;
    localparam int BIT_ELEC    = 5;
    localparam int BIT_CALRATE = 4;
    localparam int BIT_START   = 0;
    localparam int ST_CAL      = 3;
    localparam int ST_ALS      = 4;
    localparam int ST_PROX     = 5;
    // ------------------------------------------------------------
    // Datapath sizes and figures
    // ------------------------------------------------------------
    localparam int             ADC_W    = 10;
    localparam int             RES_W    = 14;
    localparam int             ACC_W    = 18;
    localparam int             SAR_W    = 9;
    localparam logic [4:0]     APC_SCALE = 5'h10;
    localparam logic [SAR_W-1:0] SAR_MID = 9'h100;
    localparam logic [3:0]     SAR_TOP  = 4'h8;
    localparam logic [7:0]     MAG_MAX  = 8'hff;
    localparam logic [2:0]     AVG_MAX  = 3'h4;
    localparam logic [3:0]     TGT_BASE = 4'h2;
    localparam logic [RES_W:0] RES_MAX  = 15'h3fff;
    localparam logic [RES_W:0] RAW_MAX  = 15'h03ff;

    // Calibration sequencer states
    typedef enum logic [3:0] {
        CAL_IDLE   = 4'b0001,
        CAL_SAMPLE = 4'b0010,
        CAL_RATE   = 4'b0100,
        CAL_DECIDE = 4'b1000
    } ppc_cal_t;

    // Whole state of the controller
    typedef struct packed {
        logic [7:0]       iscfg;
        logic [7:0]       pccfg;
        logic [7:0]       offmag;
        logic [7:0]       offsgn;
        logic [7:0]       calctl;
        logic             st_cal;
        logic             st_als;
        logic             st_prox;
        logic             sleep;
        ppc_cal_t         cal;
        logic [SAR_W-1:0] code;
        logic [3:0]       bit_idx;
        logic [4:0]       cnt;
        logic [ACC_W-1:0] acc;
        logic [7:0]       prox_lo;
        logic [7:0]       prox_hi;
        logic [7:0]       rdata;
    } ppc_state_t;
endpackage

/* hw/ppc_ctrl.sv */
// Purpose: Sleep gating, pulse control, proximity offset and offset calibration
// Assumes: Register port decoded by the serial front end, one access per strobe
// Notes:   All state in one struct, frozen while I_CE is low unless I_RST is high
//
// What this block does
// - Read-clear bit 7 set: reading status clears its flag bits.
// - Oscillator off without power-on; on unless sleep-after-irq and irq asserted.
// - Cycle end with enabled irq and sleep-after-irq set stops oscillator.
// - Sleeping acts as power off while power-on bit still reads 1.
// - Oscillator restarts once host clears pending status flags or the sleep-after-irq bit.
// - Pulse-control disable bit 6 turns automatic pulse control off.
// - Low offset register bits 7:0 hold offset magnitude.
// - High offset register bit 0 holds offset sign; rest reserved.
// - Signed offset adjusts proximity result, range plus or minus 255.
// - Calibration averaging bit 7 averages samples by configured count.
// - Calibration type bit 5: 0 electrical plus optical, 1 electrical only.
// - Electrical-only calibration disconnects photodiode, else same procedure.
// - Calibration rate bit 4 inserts proximity rate delay between averaged samples of one search step, not between steps.
// - Writing 1 to start bit 0 begins calibration sequence.
// - Electrical calibration start accepted at any time.
// - Calibration searches offset bringing result nearest the search target.
// - Completion sets calibration-done flag in status.
// - Completion loads offset magnitude and sign into offset registers.
// - Search target code n selects result target 2^(n+2)-1.
// - Pulse control off: 10-bit result, 8 MSBs low byte, 2 LSBs high.
// - Pulse control on: result is conversion times 16 over pulse count.
module ppc_ctrl (
    input  wire logic       I_CLOCK,
    input  wire logic       I_RST,
    input  wire logic       I_CE,
    input  wire logic [7:0] I_REG_ADDR,
    input  wire logic [7:0] I_REG_WDATA,
    input  wire logic       I_REG_WR,
    input  wire logic       I_REG_RD,
    output logic      [7:0] O_REG_RDATA,
    input  wire logic       I_POWER_ON,
    input  wire logic       I_ALS_IRQ_ENABLE,
    input  wire logic       I_PROX_IRQ_ENABLE,
    input  wire logic       I_ALS_IRQ_EVT,
    input  wire logic       I_PROX_IRQ_EVT,
    input  wire logic       I_CYCLE_DONE,
    input  wire logic [9:0] I_PROX_ADC,
    input  wire logic [4:0] I_PULSE_COUNT,
    input  wire logic       I_PROX_VALID,
    input  wire logic [2:0] I_SEARCH_TARGET,
    input  wire logic [2:0] I_AVG_COUNT,
    input  wire logic       I_RATE_TICK,
    output logic            O_OSC_ON,
    output logic            O_INT_N,
    output logic            O_APC_ON,
    output logic            O_PD_DISCONNECT,
    output logic            O_CAL_BUSY,
    output logic            O_CAL_SAMPLE_REQ,
    output logic            O_RATE_WAIT,
    output logic      [7:0] O_PROX_LOW,
    output logic      [7:0] O_PROX_HIGH
);
    ppc_pkg::ppc_state_t s_r;
    ppc_pkg::ppc_state_t s_nxt;

    logic                        apc_on;
    logic                        offset_calibration_control;
    logic                        irq_pend;
    logic                        irq_pend_nxt;
    logic [ppc_pkg::RES_W-1:0]   raw;
    logic [7:0]                  use_mag;
    logic                        use_sgn;
    logic [ppc_pkg::RES_W:0]     adj;
    logic [ppc_pkg::RES_W:0]     sum;
    logic [2:0]                  avg_shift;
    logic [4:0]                  nsamp;
    logic [ppc_pkg::ACC_W-1:0]   avg;
    logic [ppc_pkg::ACC_W-1:0]   target;
    logic [ppc_pkg::SAR_W-1:0]   fin_code;
    logic [7:0]                  code_mag;
    logic                        code_sgn;
    logic                        cal_go;

    // ------------------------------------------------------------
    // Search code to sign and magnitude
    // ------------------------------------------------------------
    // Code is offset plus 256; code 0 saturates to -255
    function automatic logic [8:0] code_to_sm(input logic [ppc_pkg::SAR_W-1:0] c);
        logic [ppc_pkg::SAR_W-1:0] m;
        m = ppc_pkg::SAR_MID - c;
        if (c[ppc_pkg::SAR_W-1]) begin
            code_to_sm = {1'b0, c[7:0]};
        end else if (m[ppc_pkg::SAR_W-1]) begin
            code_to_sm = {1'b1, ppc_pkg::MAG_MAX};
        end else begin
            code_to_sm = {1'b1, m[7:0]};
        end
    endfunction

    // ------------------------------------------------------------
    // Proximity datapath
    // ------------------------------------------------------------
    // Scaled result, offset applied, then clamped to the result range
    always_comb begin
        apc_on = ~s_r.pccfg[ppc_pkg::BIT_PCOFF];
        offset_calibration_control = (s_r.cal != ppc_pkg::CAL_IDLE);
        {code_sgn, code_mag} = code_to_sm(s_r.code);
        if (I_PULSE_COUNT == 5'h00) begin
            raw = {I_PROX_ADC, 4'h0};
        end else begin
            raw = ppc_pkg::RES_W'(({I_PROX_ADC, 4'h0}) / {9'h000, I_PULSE_COUNT});
        end
        if (!apc_on) begin
            raw = {4'h0, I_PROX_ADC};
        end
        use_mag = offset_calibration_control ? code_mag : s_r.offmag;
        use_sgn = offset_calibration_control ? code_sgn : s_r.offsgn[ppc_pkg::BIT_SIGN];
        // Positive offset removes crosstalk; negative offset adds back
        if (use_sgn) begin
            sum = {1'b0, raw} + {7'h00, use_mag};
        end else begin
            sum = {1'b0, raw} - {7'h00, use_mag};
        end
        if (!use_sgn && ({1'b0, raw} < {7'h00, use_mag})) begin
            adj = '0;
        end else if (apc_on && sum > ppc_pkg::RES_MAX) begin
            adj = ppc_pkg::RES_MAX;
        end else if (!apc_on && sum > ppc_pkg::RAW_MAX) begin
            adj = ppc_pkg::RAW_MAX;
        end else begin
            adj = sum;
        end
    end

    // ------------------------------------------------------------
    // Calibration figures
    // ------------------------------------------------------------
    // Sample count, average and target of the binary search
    always_comb begin
        if (!s_r.calctl[ppc_pkg::BIT_CAL_AVERAGING_ON]) begin
            avg_shift = 3'h0;
        end else if (I_AVG_COUNT > ppc_pkg::AVG_MAX) begin
            avg_shift = ppc_pkg::AVG_MAX;
        end else begin
            avg_shift = I_AVG_COUNT;
        end
        nsamp = 5'h01 << avg_shift;
        avg = s_r.acc >> avg_shift;
        target = (ppc_pkg::ACC_W'(1) << ({1'b0, I_SEARCH_TARGET} + ppc_pkg::TGT_BASE))
                 - ppc_pkg::ACC_W'(1);
        // Trial bit stays only while the result is still above target
        fin_code = s_r.code;
        if (avg <= target) begin
            fin_code[s_r.bit_idx] = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        irq_pend = (s_r.st_als & I_ALS_IRQ_ENABLE) | (s_r.st_prox & I_PROX_IRQ_ENABLE);
        irq_pend_nxt = 1'b0;
        cal_go = I_REG_WR && (I_REG_ADDR == ppc_pkg::ADDR_CALCTL) && I_REG_WDATA[ppc_pkg::BIT_START];

        // Register writes; status clears by writing ones
        if (I_REG_WR) begin
            unique case (I_REG_ADDR)
                ppc_pkg::ADDR_ISCFG:  s_nxt.iscfg = I_REG_WDATA;
                ppc_pkg::ADDR_PCCFG:  s_nxt.pccfg = I_REG_WDATA;
                ppc_pkg::ADDR_OFFMAG: s_nxt.offmag = I_REG_WDATA;
                ppc_pkg::ADDR_OFFSGN: s_nxt.offsgn = I_REG_WDATA;
                ppc_pkg::ADDR_CALCTL: begin
                    s_nxt.calctl = I_REG_WDATA;
                end
                ppc_pkg::ADDR_STATUS: begin
                    if (I_REG_WDATA[ppc_pkg::ST_CAL]) s_nxt.st_cal = 1'b0;
                    if (I_REG_WDATA[ppc_pkg::ST_ALS]) s_nxt.st_als = 1'b0;
                    if (I_REG_WDATA[ppc_pkg::ST_PROX]) s_nxt.st_prox = 1'b0;
                end
                default: ;
            endcase
        end

        // Register reads; status may clear on read
        if (I_REG_RD) begin
            unique case (I_REG_ADDR)
                ppc_pkg::ADDR_ISCFG:  s_nxt.rdata = s_r.iscfg;
                ppc_pkg::ADDR_PCCFG:  s_nxt.rdata = s_r.pccfg;
                ppc_pkg::ADDR_OFFMAG: s_nxt.rdata = s_r.offmag;
                ppc_pkg::ADDR_OFFSGN: s_nxt.rdata = s_r.offsgn;
                ppc_pkg::ADDR_CALCTL: s_nxt.rdata = s_r.calctl;
                ppc_pkg::ADDR_STATUS: begin
                    s_nxt.rdata = 8'h00;
                    s_nxt.rdata[ppc_pkg::ST_CAL] = s_r.st_cal;
                    s_nxt.rdata[ppc_pkg::ST_ALS] = s_r.st_als;
                    s_nxt.rdata[ppc_pkg::ST_PROX] = s_r.st_prox;
                    if (s_r.iscfg[ppc_pkg::BIT_RDCLR]) begin
                        s_nxt.st_cal = 1'b0;
                        s_nxt.st_als = 1'b0;
                        s_nxt.st_prox = 1'b0;
                    end
                end
                default: s_nxt.rdata = 8'h00;
            endcase
        end

        // Calibration sequencer
        unique case (s_r.cal)
            ppc_pkg::CAL_IDLE: ;
            ppc_pkg::CAL_SAMPLE: begin
                if (I_PROX_VALID) begin
                    s_nxt.acc = s_r.acc + ppc_pkg::ACC_W'(adj);
                    s_nxt.cnt = s_r.cnt + 5'h01;
                    if (s_r.cnt + 5'h01 == nsamp) begin
                        s_nxt.cal = ppc_pkg::CAL_DECIDE;
                    end else if (s_r.calctl[ppc_pkg::BIT_CALRATE]) begin
                        s_nxt.cal = ppc_pkg::CAL_RATE;
                    end
                end
            end
            ppc_pkg::CAL_RATE: begin
                if (I_RATE_TICK) begin
                    s_nxt.cal = ppc_pkg::CAL_SAMPLE;
                end
            end
            ppc_pkg::CAL_DECIDE: begin
                s_nxt.acc = '0;
                s_nxt.cnt = 5'h00;
                if (s_r.bit_idx == 4'h0) begin
                    // Search over: publish the result and flag it
                    {s_nxt.offsgn[ppc_pkg::BIT_SIGN], s_nxt.offmag} = code_to_sm(fin_code);
                    s_nxt.calctl[ppc_pkg::BIT_START] = 1'b0;
                    s_nxt.code = fin_code;
                    s_nxt.cal = ppc_pkg::CAL_IDLE;
                end else begin
                    s_nxt.code = fin_code;
                    s_nxt.code[s_r.bit_idx - 4'h1] = 1'b1;
                    s_nxt.bit_idx = s_r.bit_idx - 4'h1;
                    s_nxt.cal = ppc_pkg::CAL_SAMPLE;
                end
            end
            default: s_nxt.cal = ppc_pkg::CAL_IDLE;
        endcase

        // A start restarts the search even mid-sequence, after any step
        if (cal_go) begin
            s_nxt.cal = ppc_pkg::CAL_SAMPLE;
            s_nxt.code = ppc_pkg::SAR_MID;
            s_nxt.bit_idx = ppc_pkg::SAR_TOP;
            s_nxt.cnt = 5'h00;
            s_nxt.acc = '0;
        end

        // Hardware events set flags after any clear, so a set wins
        if (s_r.cal == ppc_pkg::CAL_DECIDE && s_r.bit_idx == 4'h0) begin
            s_nxt.st_cal = 1'b1;
        end
        if (I_ALS_IRQ_EVT) s_nxt.st_als = 1'b1;
        if (I_PROX_IRQ_EVT) s_nxt.st_prox = 1'b1;

        // Normal result bytes; held during calibration
        if (I_PROX_VALID && !offset_calibration_control) begin
            if (apc_on) begin
                s_nxt.prox_lo = adj[7:0];
                s_nxt.prox_hi = {2'h0, adj[ppc_pkg::RES_W-1:8]};
            end else begin
                s_nxt.prox_lo = adj[ppc_pkg::ADC_W-1:2];
                s_nxt.prox_hi = {6'h00, adj[1:0]};
            end
        end

        // Sleep latches at cycle end, released once flags are cleared
        irq_pend_nxt = (s_nxt.st_als & I_ALS_IRQ_ENABLE) | (s_nxt.st_prox & I_PROX_IRQ_ENABLE);
        if (I_CYCLE_DONE && irq_pend_nxt && s_r.iscfg[ppc_pkg::BIT_SAI]) begin
            s_nxt.sleep = 1'b1;
        end else if (!irq_pend_nxt) begin
            s_nxt.sleep = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            s_r <= '0;
            s_r.iscfg <= ppc_pkg::RST_ISCFG;
            s_r.pccfg <= ppc_pkg::RST_PCCFG;
            s_r.offmag <= ppc_pkg::RST_OFFMAG;
            s_r.offsgn <= ppc_pkg::RST_OFFSGN;
            s_r.calctl <= ppc_pkg::RST_CALCTL;
            s_r.cal <= ppc_pkg::CAL_IDLE;
        end else if (I_CE) begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Power-on input is never altered, so it still reads back as set
    // With sleep-after-irq set, an asserted interrupt also holds the oscillator off
    assign O_OSC_ON = I_POWER_ON & ~(s_r.iscfg[ppc_pkg::BIT_SAI] & (s_r.sleep | irq_pend));
    assign O_INT_N = ~irq_pend;
    assign O_APC_ON = apc_on;
    assign O_PD_DISCONNECT = offset_calibration_control & s_r.calctl[ppc_pkg::BIT_ELEC];
    assign O_CAL_BUSY = offset_calibration_control;
    assign O_CAL_SAMPLE_REQ = (s_r.cal == ppc_pkg::CAL_SAMPLE);
    assign O_RATE_WAIT = (s_r.cal == ppc_pkg::CAL_RATE);
    assign O_REG_RDATA = s_r.rdata;
    assign O_PROX_LOW = s_r.prox_lo;
    assign O_PROX_HIGH = s_r.prox_hi;
endmodule

/* tb/ppc_ctrl_chk.sv */
// Purpose: Port-level assertions for the offset calibration controller
// Assumes: Shadow bits follow register writes at the same edge as the design
// Notes:   Bound to every controller instance
module ppc_chk (
    input wire logic       I_CLOCK,
    input wire logic       I_RST,
    input wire logic       I_CE,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    input wire logic       I_REG_WR,
    input wire logic       I_REG_RD,
    input wire logic       I_POWER_ON,
    input wire logic       I_CYCLE_DONE,
    input wire logic       I_PROX_VALID,
    input wire logic       O_OSC_ON,
    input wire logic       O_INT_N,
    input wire logic       O_APC_ON,
    input wire logic       O_PD_DISCONNECT,
    input wire logic       O_CAL_BUSY,
    input wire logic       O_CAL_SAMPLE_REQ,
    input wire logic       O_RATE_WAIT,
    input wire logic [7:0] O_PROX_HIGH
);
    timeunit 1ns;
    timeprecision 1ns;
    logic sai_r;
    logic pcoff_r;
    logic crate_r;
    logic wr;
    logic start;
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_RST);
    // Decoded write strobes
    assign wr = I_CE && I_REG_WR;
    assign start = wr && I_REG_ADDR == ppc_pkg::ADDR_CALCTL && I_REG_WDATA[0];
    // Shadow copies of the configuration bits that gate outputs
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            sai_r <= 1'b0;
            pcoff_r <= 1'b0;
            crate_r <= 1'b0;
        end else begin
            sai_r <= (wr && I_REG_ADDR == ppc_pkg::ADDR_ISCFG) ? I_REG_WDATA[4] : sai_r;
            pcoff_r <= (wr && I_REG_ADDR == ppc_pkg::ADDR_PCCFG) ? I_REG_WDATA[6] : pcoff_r;
            crate_r <= (wr && I_REG_ADDR == ppc_pkg::ADDR_CALCTL) ? I_REG_WDATA[4] : crate_r;
        end
    end
    a_osc_unpowered: assert property (!I_POWER_ON |-> !O_OSC_ON) else $error("osc runs unpowered");
    a_osc_awake: assert property (I_POWER_ON && !sai_r |-> O_OSC_ON) else $error("osc stopped");
    a_sleep_entry: assert property (I_CE && I_CYCLE_DONE && !O_INT_N && sai_r && !I_REG_WR |=> !O_OSC_ON)
        else $error("no sleep after irq");
    a_sleep_holds: assert property (I_POWER_ON && !O_OSC_ON && !O_INT_N && !I_REG_WR && !I_REG_RD
        |=> !O_OSC_ON || !I_POWER_ON) else $error("woke with irq pending");
    a_apc_follows: assert property (O_APC_ON == !pcoff_r) else $error("pulse control level wrong");
    a_cal_starts: assert property (start |=> O_CAL_BUSY && O_CAL_SAMPLE_REQ) else $error("cal not started");
    a_pd_type: assert property (start |=> O_PD_DISCONNECT == $past(I_REG_WDATA[5])) else $error("pd wrong");
    a_pd_in_cal: assert property (O_PD_DISCONNECT |-> O_CAL_BUSY) else $error("pd outside cal");
    a_rate_gated: assert property (O_RATE_WAIT |-> crate_r && !O_CAL_SAMPLE_REQ) else $error("rate wait");
    a_raw_width: assert property (I_CE && I_PROX_VALID && !O_CAL_BUSY && !O_APC_ON
        |=> O_PROX_HIGH[7:2] == 6'h00) else $error("raw result too wide");
endmodule
bind ppc_ctrl ppc_chk u_chk (.I_CLOCK, .I_RST, .I_CE, .I_REG_ADDR, .I_REG_WDATA, .I_REG_WR, .I_REG_RD, .I_POWER_ON,
    .I_CYCLE_DONE, .I_PROX_VALID, .O_OSC_ON, .O_INT_N, .O_APC_ON, .O_PD_DISCONNECT, .O_CAL_BUSY,
    .O_CAL_SAMPLE_REQ, .O_RATE_WAIT, .O_PROX_HIGH);

/* tb/ppc_afe_model.sv */
// Purpose: Front end model answering sample and rate requests
// Assumes: Requests are levels held until answered
// Notes:   Conversion lines carry junk outside the valid strobe
module ppc_afe (
    input  wire logic       i_clock,
    input  wire logic       i_rst,
    input  wire logic       i_sample_req,
    input  wire logic       i_rate_wait,
    input  wire logic       i_slow,
    input  wire logic       i_kick,
    input  wire logic [9:0] i_level,
    output logic            o_valid,
    output logic            o_rate_tick,
    output logic      [9:0] o_adc
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] cnt_r;
    logic       due;
    assign due = cnt_r == (i_slow ? 3'h7 : 3'h1);
    // Answer a pending request after a short or long delay, or on a kick
    always_ff @(posedge i_clock) begin
        if (i_rst || i_kick || !(i_sample_req || i_rate_wait) || o_valid || o_rate_tick) begin
            cnt_r <= 3'h0;
        end else begin
            cnt_r <= cnt_r + 3'h1;
        end
        o_valid <= !i_rst && (i_kick || (due && i_sample_req && !o_valid));
        o_rate_tick <= !i_rst && due && i_rate_wait && !o_rate_tick;
    end
    // Inverse value while not strobed so stale data never matches
    assign o_adc = o_valid ? i_level : ~i_level;
endmodule

/* tb/tb_top.sv */
// Purpose: Self-checking bench for the offset calibration controller
// Assumes: Front end model feeds conversions during calibration
// Notes:   Inputs change on the falling clock edge
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk, rst, wr, rd, power_on_bit, aen, pen, aevt, pevt, cdone, kick, slow, ce;
    logic       valid, tick, osc, intn, automatic_pulse_control, pd, busy, sreq, rwait;
    logic [7:0] addr, wdata, rdata, plo, phi, nvalid, nrate;
    logic [9:0] level, adc;
    logic [4:0] pulses;
    logic [2:0] tgt, avg;
    int         failures, compares;
    ppc_ctrl uut (.I_CLOCK(clk), .I_RST(rst), .I_CE(ce), .I_REG_ADDR(addr), .I_REG_WDATA(wdata),
        .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata), .I_POWER_ON(power_on_bit), .I_ALS_IRQ_ENABLE(aen),
        .I_PROX_IRQ_ENABLE(pen), .I_ALS_IRQ_EVT(aevt), .I_PROX_IRQ_EVT(pevt), .I_CYCLE_DONE(cdone),
        .I_PROX_ADC(adc), .I_PULSE_COUNT(pulses), .I_PROX_VALID(valid), .I_SEARCH_TARGET(tgt),
        .I_AVG_COUNT(avg), .I_RATE_TICK(tick), .O_OSC_ON(osc), .O_INT_N(intn), .O_APC_ON(automatic_pulse_control),
        .O_PD_DISCONNECT(pd), .O_CAL_BUSY(busy), .O_CAL_SAMPLE_REQ(sreq), .O_RATE_WAIT(rwait),
        .O_PROX_LOW(plo), .O_PROX_HIGH(phi));
    ppc_afe afe (.i_clock(clk), .i_rst(rst), .i_sample_req(sreq), .i_rate_wait(rwait), .i_slow(slow),
        .i_kick(kick), .i_level(level), .o_valid(valid), .o_rate_tick(tick), .o_adc(adc));
    // Clock and request counters
    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (valid && sreq)
            nvalid <= nvalid + 8'h01;
        if (tick && rwait)
            nrate <= nrate + 8'h01;
    end
    task automatic conclude();
        if (failures == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic rd8(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk(rdata, e);
    endtask
    task automatic sample(input logic [7:0] lo, input logic [7:0] hi);
        kick = 1'b1;
        @(negedge clk);
        kick = 1'b0;
        @(negedge clk);
        chk(plo, lo);
        chk(phi, hi);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 3000 && busy !== 1'b0; i++)
            @(negedge clk);
        if (busy !== 1'b0) begin
            failures++;
            conclude();
        end
    endtask
    // Main sequence
    initial begin
        {clk, wr, rd, aen, pen, aevt, pevt, cdone, kick, slow, addr, wdata, nvalid, nrate} = '0;
        {rst, power_on_bit, failures, compares, level, pulses, tgt, avg} = {2'b11, 64'h0, 10'h067, 5'h08, 3'h2, 3'h0};
        ce = 1'b1;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        rd8(ppc_pkg::ADDR_ISCFG, 8'h01);
        rd8(ppc_pkg::ADDR_PCCFG, 8'h3f);
        rd8(ppc_pkg::ADDR_CALCTL, 8'h00);
        rd8(8'h10, 8'h00);
        // Clock enable low: a write must not land
        ce = 1'b0;
        wr8(ppc_pkg::ADDR_OFFMAG, 8'h3c);
        ce = 1'b1;
        rd8(ppc_pkg::ADDR_OFFMAG, 8'h00);
        wr8(ppc_pkg::ADDR_OFFMAG, 8'ha5);
        wr8(ppc_pkg::ADDR_OFFSGN, 8'h01);
        rd8(ppc_pkg::ADDR_OFFMAG, 8'ha5);
        rd8(ppc_pkg::ADDR_OFFSGN, 8'h01);
        sample(8'h73, 8'h01);
        wr8(ppc_pkg::ADDR_OFFSGN, 8'h00);
        wr8(ppc_pkg::ADDR_OFFMAG, 8'h05);
        sample(8'hc9, 8'h00);
        wr8(ppc_pkg::ADDR_OFFMAG, 8'hff);
        sample(8'h00, 8'h00);
        wr8(ppc_pkg::ADDR_OFFMAG, 8'h00);
        wr8(ppc_pkg::ADDR_PCCFG, 8'h7f);
        chk({7'h00, automatic_pulse_control}, 8'h00);
        sample(8'h19, 8'h03);
        wr8(ppc_pkg::ADDR_PCCFG, 8'h3f);
        chk({7'h00, automatic_pulse_control}, 8'h01);
        // Optical calibration, result loaded and flagged
        wr8(ppc_pkg::ADDR_OFFSGN, 8'h01);
        wr8(ppc_pkg::ADDR_CALCTL, 8'h01);
        chk({6'h00, busy, pd}, 8'h02);
        wait_idle();
        rd8(ppc_pkg::ADDR_OFFMAG, 8'hbe);
        rd8(ppc_pkg::ADDR_OFFSGN, 8'h00);
        rd8(ppc_pkg::ADDR_CALCTL, 8'h00);
        rd8(ppc_pkg::ADDR_STATUS, 8'h08);
        rd8(ppc_pkg::ADDR_STATUS, 8'h08);
        wr8(ppc_pkg::ADDR_STATUS, 8'h08);
        rd8(ppc_pkg::ADDR_STATUS, 8'h00);
        // Restart as electrical, averaged, rate paced, while powered off
        {slow, power_on_bit, avg} = {2'b10, 3'h1};
        wr8(ppc_pkg::ADDR_CALCTL, 8'h01);
        repeat (30) @(negedge clk);
        wr8(ppc_pkg::ADDR_CALCTL, 8'hb1);
        nvalid = 8'h00;
        chk({7'h00, pd}, 8'h01);
        wait_idle();
        chk(nvalid, 8'h12);
        chk({7'h00, nrate != 8'h00}, 8'h01);
        rd8(ppc_pkg::ADDR_OFFMAG, 8'hbe);
        wr8(ppc_pkg::ADDR_ISCFG, 8'h81);
        rd8(ppc_pkg::ADDR_STATUS, 8'h08);
        rd8(ppc_pkg::ADDR_STATUS, 8'h00);
        // Sleep after interrupt, woken by write-one-to-clear
        {power_on_bit, pen} = 2'b11;
        wr8(ppc_pkg::ADDR_ISCFG, 8'h11);
        pevt = 1'b1;
        @(negedge clk);
        {pevt, cdone} = 2'b01;
        chk({7'h00, intn}, 8'h00);
        @(negedge clk);
        cdone = 1'b0;
        chk({7'h00, osc}, 8'h00);
        repeat (5) @(negedge clk);
        chk({7'h00, osc}, 8'h00);
        wr8(ppc_pkg::ADDR_STATUS, 8'h20);
        @(negedge clk);
        chk({7'h00, osc}, 8'h01);
        power_on_bit = 1'b0;
        @(negedge clk);
        chk({7'h00, osc}, 8'h00);
        // Ambient flag woken by read-clear
        {power_on_bit, aen, pen, aevt} = 4'b1101;
        wr8(ppc_pkg::ADDR_ISCFG, 8'h91);
        {aevt, cdone} = 2'b01;
        @(negedge clk);
        cdone = 1'b0;
        chk({7'h00, osc}, 8'h00);
        rd8(ppc_pkg::ADDR_STATUS, 8'h10);
        @(negedge clk);
        chk({7'h00, osc}, 8'h01);
        conclude();
    end
endmodule
